/* File: cci_pkg.sv */
// Constants, register map and carrier types for the camera capture unit
package cci_pkg;

  // Register byte offsets
  localparam logic [5:0]  CCI_OFF_DEPTH  = 6'h04;
  localparam logic [5:0]  CCI_OFF_CTRL   = 6'h08;
  localparam logic [5:0]  CCI_OFF_STATUS = 6'h18;
  localparam logic [5:0]  CCI_OFF_MASK   = 6'h1c;
  localparam logic [5:0]  CCI_OFF_DATA   = 6'h30;

  // Buffer geometry and reset values
  localparam int unsigned CCI_FIFO_DEPTH = 8;
  localparam logic [31:0] CCI_DEPTH_VAL  = 32'h0000_0008;
  localparam logic [31:0] CCI_CTRL_RST   = 32'h0002_0020;
  localparam logic [31:0] CCI_CTRL_WMASK = 32'hc01f_03ff;
  localparam logic [31:0] CCI_ZERO_WORD  = 32'h0000_0000;

  // Capture mode and pixel width encodings
  localparam logic [1:0]  CCI_MODE_OFF    = 2'h0;
  localparam logic [1:0]  CCI_MODE_SINGLE = 2'h1;
  localparam logic [1:0]  CCI_MODE_CONT   = 2'h2;
  localparam logic [1:0]  CCI_WIDTH_8     = 2'h0;
  localparam logic [1:0]  CCI_WIDTH_10    = 2'h1;
  localparam logic [1:0]  CCI_WIDTH_12    = 2'h2;

  // Event status bit positions
  localparam int unsigned CCI_EVT_W    = 3;
  localparam int unsigned CCI_EVT_DONE = 0;
  localparam int unsigned CCI_EVT_THR  = 1;
  localparam int unsigned CCI_EVT_OVF  = 2;

  // Control register layout, bit 31 down to bit 0
  typedef struct packed {
    logic       enable;
    logic       nn_pixel_expand_enable;
    logic [8:0] rsvd_hi;
    logic [3:0] dma_thresh;
    logic       dma_enable;
    logic [5:0] rsvd_mid;
    logic [4:0] fifo_thresh;
    logic       timing_sel;
    logic [1:0] pixel_width;
    logic [1:0] capture_mode;
  } cci_ctrl_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } cci_avl_req_t;

  // Camera pins
  typedef struct packed {
    logic        pclk;
    logic        vsync;
    logic        href;
    logic [11:0] data;
  } cci_pix_t;

  // Capture sequencer states
  typedef enum logic [2:0] {
    CCI_CAP_OFF  = 3'h1,
    CCI_CAP_RUN  = 3'h2,
    CCI_CAP_HALT = 3'h4
  } cci_cap_t;

endpackage

/* File: cci_capture.sv */
// Camera capture unit: pixel sampling, word packing, FIFO, DMA request, registers
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Depth register read-only, reads 8, upper zero
// - Capture inactive unless enable bit set
// - Expand mode widens 5:6:5 into left-aligned 8:8:8
// - Expand mode gives one padded word per pixel
// - DMA request when FIFO level reaches threshold
// - Threshold 1 to 8; 8 means full
// - Threshold ignored unless DMA enable set
// - DMA enable bit allows requests, resets zero
// - DMA disabled clears pending request immediately
// - Mode: off, single image, continuous
// - Width 8, 10 or 12 bits; code 3 acts as 12
// - Buffer is eight 32-bit words
module cci_capture
  import cci_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  // Avalon-MM slave
  input  wire cci_pkg::cci_avl_req_t i_avl,
  output logic [31:0]                o_avl_readdata,
  output logic                       o_avl_waitrequest,
  // Camera pins
  input  wire cci_pkg::cci_pix_t     i_pix,
  // DMA and interrupt
  output logic                       o_rx_dma_req,
  output logic                       o_irq
);
  import cci_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  // Whole module state, registered as one word
  typedef struct packed {
    cci_pix_t                          pix_s1;
    cci_pix_t                          pix_s2;
    cci_pix_t                          pix_s3;
    cci_ctrl_t                         ctrl;
    logic [CCI_EVT_W-1:0]              status;
    logic [CCI_EVT_W-1:0]              mask;
    cci_cap_t                          cap;
    logic                              frame_seen;
    logic [31:0]                       acc;
    logic [1:0]                        acc_cnt;
    logic [CCI_FIFO_DEPTH-1:0][31:0]   mem;
    logic [2:0]                        wr_ptr;
    logic [2:0]                        rd_ptr;
    logic [3:0]                        level;
    logic                              thr_prev;
    logic                              pend_pop;
    logic [CCI_EVT_W-1:0]              pend_clr;
    logic                              waitreq;
    logic [31:0]                       rdata;
    logic                              dma_req;
    logic                              irq;
  } cci_state_t;

  cci_state_t s_q;
  cci_state_t s_d;

  // Left-aligned 8:8:8 from 5:6:5, top byte padded
  function automatic logic [31:0] cci_expand(input logic [15:0] p);
    cci_expand = {8'h00, p[15:11], 3'h0, p[10:5], 2'h0, p[4:0], 3'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Byte lanes

  logic [31:0] lane_mask;

  for (genvar b = 0; b < 4; b++)
  begin : g_lane
    assign lane_mask[8*b +: 8] = {8{i_avl.byteenable[b]}};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic                 pclk_rise;
    logic                 vsync_rise;
    logic                 take;
    logic                 push;
    logic                 pop;
    logic                 done_evt;
    logic                 ovf_evt;
    logic                 thr_now;
    logic                 accept;
    logic                 acc_sel;
    logic                 mode_ok;
    logic                 dma_hit;
    logic [15:0]          p16;
    logic [31:0]          word;
    logic [31:0]          wmask;
    logic [31:0]          rd;
    logic [CCI_EVT_W-1:0] set;
    logic [CCI_EVT_W-1:0] clr;
    pclk_rise  = 1'b0;
    vsync_rise = 1'b0;
    take       = 1'b0;
    push       = 1'b0;
    pop        = 1'b0;
    done_evt   = 1'b0;
    ovf_evt    = 1'b0;
    thr_now    = 1'b0;
    accept     = 1'b0;
    acc_sel    = 1'b0;
    mode_ok    = 1'b0;
    dma_hit    = 1'b0;
    p16        = 16'h0000;
    word       = CCI_ZERO_WORD;
    wmask      = CCI_ZERO_WORD;
    rd         = CCI_ZERO_WORD;
    set        = '0;
    clr        = '0;
    s_d        = s_q;

    // Pin synchronisers
    s_d.pix_s1 = i_pix;
    s_d.pix_s2 = s_q.pix_s1;
    s_d.pix_s3 = s_q.pix_s2;
    pclk_rise  = s_q.pix_s2.pclk & ~s_q.pix_s3.pclk;
    vsync_rise = s_q.pix_s2.vsync & ~s_q.pix_s3.vsync;

    // Reserved mode 3 counts as disabled
    mode_ok    = s_q.ctrl.enable &&
                 (s_q.ctrl.capture_mode == CCI_MODE_SINGLE ||
                  s_q.ctrl.capture_mode == CCI_MODE_CONT);

    // Capture sequencer
    case (s_q.cap)
      CCI_CAP_OFF:
      begin
        if (mode_ok)
        begin
          s_d.cap = CCI_CAP_RUN;
        end
        s_d.frame_seen = 1'b0;
        s_d.acc_cnt    = 2'h0;
      end
      CCI_CAP_RUN:
      begin
        if (!mode_ok)
        begin
          s_d.cap = CCI_CAP_OFF;
        end
        else if (vsync_rise && s_q.frame_seen)
        begin
          done_evt       = 1'b1;
          s_d.frame_seen = 1'b0;
          s_d.acc_cnt    = 2'h0;
          if (s_q.ctrl.capture_mode == CCI_MODE_SINGLE)
          begin
            s_d.cap = CCI_CAP_HALT;
          end
        end
        else if (pclk_rise && s_q.pix_s2.href && !s_q.pix_s2.vsync)
        begin
          take           = 1'b1;
          s_d.frame_seen = 1'b1;
        end
      end
      // Single image done: hold until software changes mode or clears enable
      CCI_CAP_HALT:
      begin
        if (!s_q.ctrl.enable || s_q.ctrl.capture_mode != CCI_MODE_SINGLE)
        begin
          s_d.cap = CCI_CAP_OFF;
        end
      end
      default:
      begin
        s_d.cap = CCI_CAP_OFF;
      end
    endcase

    // Word packing, newest sample in the high part; 8-bit expand puts the first byte high
    // Width select masks the unused high data pins
    if (take)
    begin
      if (s_q.ctrl.pixel_width == CCI_WIDTH_8)
      begin
        if (s_q.ctrl.nn_pixel_expand_enable)
        begin
          s_d.acc[7:0] = s_q.pix_s2.data[7:0];
          acc_sel      = s_q.acc_cnt[0];
          s_d.acc_cnt  = {1'b0, ~s_q.acc_cnt[0]};
          p16          = {s_q.acc[7:0], s_q.pix_s2.data[7:0]};
          word         = cci_expand(p16);
          push         = acc_sel;
        end
        else
        begin
          s_d.acc     = {s_q.pix_s2.data[7:0], s_q.acc[31:8]};
          s_d.acc_cnt = 2'(s_q.acc_cnt + 2'h1);
          word        = s_d.acc;
          push        = (s_q.acc_cnt == 2'h3);
        end
      end
      else
      begin
        p16 = (s_q.ctrl.pixel_width == CCI_WIDTH_10) ?
              {6'h00, s_q.pix_s2.data[9:0]} : {4'h0, s_q.pix_s2.data[11:0]};
        if (s_q.ctrl.nn_pixel_expand_enable)
        begin
          word = cci_expand(p16);
          push = 1'b1;
        end
        else
        begin
          s_d.acc     = {p16, s_q.acc[31:16]};
          s_d.acc_cnt = {1'b0, ~s_q.acc_cnt[0]};
          word        = s_d.acc;
          push        = s_q.acc_cnt[0];
        end
      end
    end

    // Avalon slave: one wait cycle, then completion
    // Read data captured at acceptance, held until the next read
    accept      = (i_avl.read || i_avl.write) && s_q.waitreq;
    s_d.waitreq = ~accept;
    if (accept && i_avl.read)
    begin
      case (i_avl.address)
        CCI_OFF_DEPTH:  rd = CCI_DEPTH_VAL;
        CCI_OFF_CTRL:   rd = s_q.ctrl & CCI_CTRL_WMASK;
        CCI_OFF_STATUS: rd = {29'h0, s_q.status};
        CCI_OFF_MASK:   rd = {29'h0, s_q.mask};
        CCI_OFF_DATA:   rd = (s_q.level != 4'h0) ? s_q.mem[s_q.rd_ptr] : CCI_ZERO_WORD;
        default:        rd = CCI_ZERO_WORD;
      endcase
      s_d.rdata    = rd;
      s_d.pend_pop = (i_avl.address == CCI_OFF_DATA) && (s_q.level != 4'h0);
      s_d.pend_clr = (i_avl.address == CCI_OFF_STATUS) ? s_q.status : '0;
    end
    else if (accept)
    begin
      s_d.pend_pop = 1'b0;
      s_d.pend_clr = '0;
    end

    // Effects take place at the completing edge
    // A request dropped before completion has no side effect
    if (!s_q.waitreq && i_avl.read)
    begin
      pop = s_q.pend_pop;
      clr = s_q.pend_clr;
    end
    if (!s_q.waitreq && i_avl.write)
    begin
      wmask = lane_mask;
      if (i_avl.address == CCI_OFF_CTRL)
      begin
        wmask    = wmask & CCI_CTRL_WMASK;
        s_d.ctrl = (s_q.ctrl & ~wmask) | (i_avl.writedata & wmask);
      end
      else if (i_avl.address == CCI_OFF_MASK)
      begin
        s_d.mask = (s_q.mask & ~wmask[CCI_EVT_W-1:0]) |
                   (i_avl.writedata[CCI_EVT_W-1:0] & wmask[CCI_EVT_W-1:0]);
      end
    end

    // FIFO of eight words, overflow drops the new word
    if (push && s_q.level == 4'(CCI_FIFO_DEPTH))
    begin
      ovf_evt = 1'b1;
      push    = 1'b0;
    end
    if (push)
    begin
      s_d.mem[s_q.wr_ptr] = word;
      s_d.wr_ptr          = 3'(s_q.wr_ptr + 3'h1);
    end
    if (pop)
    begin
      s_d.rd_ptr = 3'(s_q.rd_ptr + 3'h1);
    end
    s_d.level = 4'(s_q.level + {3'h0, push} - {3'h0, pop});

    // Events: set wins over a read clear
    // Threshold event fires on the crossing only
    thr_now          = ({1'b0, s_d.level} >= s_q.ctrl.fifo_thresh);
    s_d.thr_prev     = thr_now;
    set              = '0;
    set[CCI_EVT_DONE] = done_evt;
    set[CCI_EVT_THR]  = thr_now & ~s_q.thr_prev;
    set[CCI_EVT_OVF]  = ovf_evt;
    s_d.status       = (s_q.status & ~clr) | set;
    s_d.irq          = |(s_d.status & s_d.mask);

    // DMA request follows level against threshold
    // Built from next state, so a disable drops it at once
    dma_hit     = (s_d.ctrl.dma_thresh != 4'h0) &&
                  (s_d.level >= s_d.ctrl.dma_thresh);
    s_d.dma_req = s_d.ctrl.dma_enable && dma_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_q         <= '0;
      s_q.ctrl    <= CCI_CTRL_RST;
      s_q.cap     <= CCI_CAP_OFF;
      s_q.waitreq <= 1'b1;
      // Sync flops start at idle vsync, so no false frame end
      s_q.pix_s1.vsync <= 1'b1;
      s_q.pix_s2.vsync <= 1'b1;
      s_q.pix_s3.vsync <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_avl_readdata    = s_q.rdata;
  assign o_avl_waitrequest = s_q.waitreq;
  assign o_rx_dma_req      = s_q.dma_req;
  assign o_irq             = s_q.irq;

endmodule

`default_nettype wire

/* File: cci_cam_model.sv */
// Camera sensor model driving the pixel pins
`timescale 1ns/100ps
`default_nettype none
module cci_cam_model
  import cci_pkg::*;
(
  // Camera pins
  output var cci_pkg::cci_pix_t o_pix
);
  import cci_pkg::*;
  logic [11:0] q[$];
  // Between frames: clock still, sync high
  initial o_pix = '{1'b0, 1'b1, 1'b0, 12'ha5c};
  // Sends every queued sample; data moves on falling pclk
  task automatic frame();
    o_pix.vsync = 1'b0;
    #80;
    while (q.size() > 0)
    begin
      o_pix.href = 1'b1;
      o_pix.data = q.pop_front();
      #40 o_pix.pclk = 1'b1;
      #40 o_pix.pclk = 1'b0;
    end
    o_pix.href = 1'b0;
    o_pix.data = ~o_pix.data;
    #80 o_pix.vsync = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: cci_capture_asserts.sv */
// Port checks for the camera capture unit
`timescale 1ns/100ps
`default_nettype none
module cci_capture_asserts
  import cci_pkg::*;
(
  // Clock and reset
  input wire logic                  i_ref_clk,
  input wire logic                  i_rst_n,
  // Watched ports
  input wire cci_pkg::cci_avl_req_t i_avl,
  input wire logic [31:0]           o_avl_readdata,
  input wire logic                  o_avl_waitrequest,
  input wire cci_pkg::cci_pix_t     i_pix,
  input wire logic                  o_rx_dma_req,
  input wire logic                  o_irq
);
  import cci_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_req;
    (i_avl.read || i_avl.write) && o_avl_waitrequest;
  endsequence
  sequence s_done;
    (i_avl.read || i_avl.write) && !o_avl_waitrequest;
  endsequence
  sequence s_ctl_wr;
    s_done ##0 (i_avl.write && i_avl.address == CCI_OFF_CTRL && i_avl.byteenable[2]);
  endsequence
  bus_answer_a:
    assert property (s_req |=> !o_avl_waitrequest) else $error("no bus answer");
  wait_short_a:
    assert property (!o_avl_waitrequest |=> o_avl_waitrequest) else $error("wait low too long");
  idle_wait_a:
    assert property (!(i_avl.read || i_avl.write) [*2] |-> o_avl_waitrequest)
    else $error("wait low while idle");
  depth_value_a:
    assert property (s_req ##0 (i_avl.read && i_avl.address == CCI_OFF_DEPTH)
      |=> o_avl_readdata == 32'h0000_0008) else $error("bad depth");
  ctrl_rsvd_a:
    assert property (s_req ##0 (i_avl.read && i_avl.address == CCI_OFF_CTRL)
      |=> o_avl_readdata[29:21] == 9'h0 && o_avl_readdata[15:10] == 6'h0)
    else $error("reserved bits set");
  dma_off_a:
    assert property (s_ctl_wr ##0 !i_avl.writedata[16] |=> ##1 !o_rx_dma_req)
    else $error("request kept after disable");
  dma_zero_a:
    assert property (s_ctl_wr ##0 (i_avl.writedata[20:17] == 4'h0) |=> ##1 !o_rx_dma_req)
    else $error("request at threshold zero");
  rst_quiet_a:
    assert property ($rose(i_rst_n) |-> !o_rx_dma_req && !o_irq && o_avl_waitrequest)
    else $error("outputs busy after reset");
  rdata_hold_a:
    assert property (!(i_avl.read || i_avl.write) |=> $stable(o_avl_readdata))
    else $error("read data moved");
  cover property (o_irq && i_pix.vsync);
endmodule
`default_nettype wire

/* File: tb_camera_capture_control_dma.sv */
// Self-checking bench for the camera capture unit
`timescale 1ns/100ps
`default_nettype none
module tb_camera_capture_control_dma;
  import cci_pkg::*;
  logic         clk;
  logic         i_rst_n;
  cci_avl_req_t avl;
  wire cci_pix_t pix;
  logic [31:0]  rdat;
  logic         wt;
  logic         dreq;
  logic         irq;
  logic [31:0]  rnd;
  logic [2:0]   msk;
  int           err_total;
  int           cmp_count;
  logic [31:0]  eq[$];

  cci_capture u_cci_capture (.i_ref_clk(clk), .i_rst_n(i_rst_n), .i_avl(avl),
    .o_avl_readdata(rdat), .o_avl_waitrequest(wt), .i_pix(pix),
    .o_rx_dma_req(dreq), .o_irq(irq));
  cci_cam_model u_cci_cam_model (.o_pix(pix));

  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  function automatic logic [31:0] cf(bit en, bit ex, logic [1:0] md, logic [1:0] wd,
                                     int t, bit de);
    return {en, ex, 9'h0, 4'(t), de, 6'h0, 5'h1, 1'b0, wd, md};
  endfunction
  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    avl <= '{~w, w, a, d, 4'hf};
    @(posedge clk);
    while (wt !== 1'b0)
    begin
      n++;
      if (n > 20)
      begin
        err_total++;
        close_out();
      end
      @(posedge clk);
    end
    r = rdat;
    avl <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  // One frame against the reference model of packing and DMA
  task automatic run(input logic [31:0] c, input int nb, input bit kill);
    logic [31:0] w;
    logic [31:0] st;
    logic [11:0] p[$];
    int          sz, k, g, lv;
    bit          de, rn;
    sz = (c[3:2] == 2'h0) ? 8 : ((c[3:2] == 2'h1) ? 10 : 12);
    k = c[30] ? ((sz == 8) ? 2 : 1) : ((sz == 8) ? 4 : 2);
    g = 0;
    de = c[16];
    rn = c[31] && c[1:0] != 2'h0;
    wr(CCI_OFF_CTRL, 32'h0002_0020);
    wr(CCI_OFF_CTRL, c);
    for (int i = 0; i < nb; i++)
    begin
      p.push_back(12'(xs()));
      u_cci_cam_model.q.push_back(p[i]);
    end
    for (int i = 0; i + k <= nb; i += k)
    begin
      w = 32'h0;
      for (int j = 0; j < k; j++)
        w |= 32'(p[i + j] & 12'((1 << sz) - 1)) << (j * ((sz == 8) ? 8 : 16));
      if (c[30] && sz == 8)
        w = {16'h0, w[7:0], w[15:8]};
      if (c[30])
        w = {8'h00, w[15:11], 3'h0, w[10:5], 2'h0, w[4:0], 3'h0};
      g++;
      if (g <= 8 && rn)
        eq.push_back(w);
    end
    u_cci_cam_model.frame();
    repeat (8) @(posedge clk);
    lv = eq.size();
    st = {29'h0, rn && g > 8, lv > 0, rn && nb > 0};
    chk(dreq, de && lv >= c[20:17]);
    if (kill)
    begin
      wr(CCI_OFF_CTRL, c & 32'hfffe_ffff);
      de = 1'b0;
    end
    while (eq.size() > 0)
    begin
      repeat (2) @(posedge clk);
      chk(dreq, de && eq.size() >= c[20:17]);
      rdc(CCI_OFF_DATA, eq.pop_front());
    end
    repeat (2) @(posedge clk);
    chk(dreq, 1'b0);
    rdc(CCI_OFF_DATA, 32'h0);
    chk(irq, (st[2:0] & msk) != 3'h0);
    rdc(CCI_OFF_STATUS, st);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    $display("test end: ctrl %h samples %0d", c, nb);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    i_rst_n = 1'b0;
    avl = '0;
    rnd = 32'hd11e;
    msk = 3'h7;
    err_total = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    i_rst_n <= 1'b1;
    @(posedge clk);
    rdc(CCI_OFF_DEPTH, 32'h0000_0008);
    rdc(CCI_OFF_CTRL, 32'h0002_0020);
    wr(CCI_OFF_DEPTH, 32'hffff_ffff);
    rdc(CCI_OFF_DEPTH, 32'h0000_0008);
    rdc(6'h3c, 32'h0);
    wr(CCI_OFF_CTRL, 32'hffff_ffff);
    rdc(CCI_OFF_CTRL, 32'hc01f_03ff);
    wr(CCI_OFF_MASK, 32'h7);
    $display("test end: register map");
    for (int t = 1; t <= 8; t++)
      run(cf(1, 0, CCI_MODE_CONT, CCI_WIDTH_8, t, 1), 4 * t + t % 4, 0);
    run(cf(1, 0, CCI_MODE_CONT, CCI_WIDTH_8, 3, 1), 40, 0);
    run(cf(1, 0, CCI_MODE_CONT, CCI_WIDTH_8, 2, 0), 16, 0);
    run(cf(1, 0, CCI_MODE_CONT, CCI_WIDTH_8, 2, 1), 16, 1);
    run(cf(1, 1, CCI_MODE_CONT, CCI_WIDTH_8, 1, 1), 10, 0);
    run(cf(1, 1, CCI_MODE_CONT, CCI_WIDTH_10, 1, 1), 5, 0);
    run(cf(1, 0, CCI_MODE_CONT, CCI_WIDTH_10, 1, 1), 8, 0);
    run(cf(1, 0, CCI_MODE_CONT, CCI_WIDTH_12, 4, 1), 16, 0);
    run(cf(0, 0, CCI_MODE_CONT, CCI_WIDTH_8, 1, 1), 8, 0);
    run(cf(1, 0, CCI_MODE_OFF, CCI_WIDTH_8, 1, 1), 8, 0);
    msk = 3'h0;
    wr(CCI_OFF_MASK, 32'h0);
    run(cf(1, 0, CCI_MODE_SINGLE, CCI_WIDTH_8, 2, 1), 12, 0);
    for (int i = 0; i < 8; i++)
      u_cci_cam_model.q.push_back(12'(xs()));
    u_cci_cam_model.frame();
    repeat (8) @(posedge clk);
    rdc(CCI_OFF_DATA, 32'h0);
    rdc(CCI_OFF_STATUS, 32'h0);
    $display("test end: single image halt");
    close_out();
  end
endmodule

bind cci_capture cci_capture_asserts u_cci_capture_asserts (.i_ref_clk(i_ref_clk),
  .i_rst_n(i_rst_n), .i_avl(i_avl), .o_avl_readdata(o_avl_readdata),
  .o_avl_waitrequest(o_avl_waitrequest), .i_pix(i_pix), .o_rx_dma_req(o_rx_dma_req),
  .o_irq(o_irq));
`default_nettype wire
